// [design/pif_pkg.sv]
package pif_pkg;

	// ********************************************************
	// Register bus shape
	// ********************************************************
	localparam int PIF_AW = 3;
	localparam int PIF_DW = 8;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [PIF_AW-1:0] ADDR_CELL_EN = 3'h0;
	localparam logic [PIF_AW-1:0] ADDR_TA_FLAGS = 3'h1;
	localparam logic [PIF_AW-1:0] ADDR_CTRL = 3'h2;
	localparam logic [PIF_AW-1:0] ADDR_TA_EN = 3'h3;
	localparam logic [PIF_AW-1:0] ADDR_CELL_FLAGS = 3'h4;
	localparam logic [PIF_AW-1:0] ADDR_EVT_STAT = 3'h5;
	localparam logic [PIF_AW-1:0] ADDR_EVT_MASK = 3'h6;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int CELL2_BIT = 1;
	localparam int CELL1_BIT = 0;
	localparam int T1_GATE_BIT = 7;
	localparam int CONV_DONE_BIT = 6;
	localparam int T2_MATCH_BIT = 1;
	localparam int T1_OVF_BIT = 0;
	localparam int GLOBAL_EN_BIT = 7;
	localparam int PERIPH_EN_BIT = 6;
	localparam int EVT_CELL2_BIT = 3;
	localparam int EVT_CELL1_BIT = 2;

	// ********************************************************
	// Implemented-bit masks and reset value
	// ********************************************************
	localparam logic [PIF_DW-1:0] CELL_MASK = 8'h03;
	localparam logic [PIF_DW-1:0] TA_MASK = 8'hc3;
	localparam logic [PIF_DW-1:0] CTRL_MASK = 8'hc0;
	localparam logic [PIF_DW-1:0] EVT_MASK = 8'hcf;
	localparam logic [PIF_DW-1:0] REG_RESET = 8'h00;

endpackage

// [design/pif_flag_bank.sv]
`timescale 1ns/1ps

// ********************************************************
// Sticky flag bank: hardware sets, software writes
// ********************************************************
module pif_flag_bank
	import pif_pkg::*;
#(
	parameter logic [PIF_DW-1:0] IMPL = 8'hff
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [PIF_DW-1:0] set_evt,
	input wire logic wr_en,
	input wire logic [PIF_DW-1:0] wr_val,
	input wire logic clr_all,
	output logic [PIF_DW-1:0] flags_q
);

	logic [PIF_DW-1:0] flags_d;

	always_comb
	begin
		flags_d = flags_q;
		if (wr_en)
		begin
			flags_d = wr_val;
		end
		else if (clr_all)
		begin
			flags_d = REG_RESET;
		end
		// Set after the write so an event in the clearing cycle survives
		flags_d = (flags_d | set_evt) & IMPL;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			flags_q <= REG_RESET;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

endmodule // pif_flag_bank

// [design/pif_irq_regs.sv]
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module pif_irq_regs
	import pif_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [PIF_AW-1:0] reg_addr,
	input wire logic [PIF_DW-1:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic t1_gate_evt,
	input wire logic conv_done_evt,
	input wire logic t2_match_evt,
	input wire logic t1_overflow_evt,
	input wire logic cell1_evt,
	input wire logic cell2_evt,
	output logic [PIF_DW-1:0] reg_rd_data,
	output logic core_irq_req,
	output logic irq
);

	// ********************************************************
	// Decode helpers
	// ********************************************************
	function automatic logic hit(
		input logic strobe,
		input logic [PIF_AW-1:0] addr,
		input logic [PIF_AW-1:0] offset
	);
		hit = strobe && (addr == offset);
	endfunction

	function automatic logic any_pending(
		input logic [PIF_DW-1:0] flags,
		input logic [PIF_DW-1:0] enables
	);
		any_pending = |(flags & enables);
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	logic [PIF_DW-1:0] cell_en_q;
	logic [PIF_DW-1:0] cell_en_d;
	logic [PIF_DW-1:0] ta_en_q;
	logic [PIF_DW-1:0] ta_en_d;
	logic [PIF_DW-1:0] ctrl_q;
	logic [PIF_DW-1:0] ctrl_d;
	logic [PIF_DW-1:0] evt_mask_q;
	logic [PIF_DW-1:0] evt_mask_d;
	logic [PIF_DW-1:0] rd_data_q;
	logic [PIF_DW-1:0] rd_data_d;
	logic core_irq_q;
	logic core_irq_d;
	logic irq_q;
	logic irq_d;

	logic [PIF_DW-1:0] ta_flags_q;
	logic [PIF_DW-1:0] cell_flags_q;
	logic [PIF_DW-1:0] evt_stat_q;
	logic [PIF_DW-1:0] ta_set;
	logic [PIF_DW-1:0] cell_set;
	logic [PIF_DW-1:0] evt_set;
	logic global_irq_en;
	logic periph_irq_en;

	assign global_irq_en = ctrl_q[GLOBAL_EN_BIT];
	assign periph_irq_en = ctrl_q[PERIPH_EN_BIT];

	// ********************************************************
	// Event routing
	// ********************************************************
	always_comb
	begin
		ta_set = REG_RESET;
		ta_set[T1_GATE_BIT] = t1_gate_evt;
		ta_set[CONV_DONE_BIT] = conv_done_evt;
		ta_set[T2_MATCH_BIT] = t2_match_evt;
		ta_set[T1_OVF_BIT] = t1_overflow_evt;
		cell_set = REG_RESET;
		cell_set[CELL2_BIT] = cell2_evt;
		cell_set[CELL1_BIT] = cell1_evt;
		evt_set = ta_set;
		evt_set[EVT_CELL2_BIT] = cell2_evt;
		evt_set[EVT_CELL1_BIT] = cell1_evt;
	end

	// ********************************************************
	// Flag banks
	// ********************************************************
	// Enables are not consulted here: flags record every event
	pif_flag_bank #(
		.IMPL(TA_MASK)
	) u_ta_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.set_evt(ta_set),
		.wr_en(hit(reg_wr, reg_addr, ADDR_TA_FLAGS)),
		.wr_val(reg_wr_data),
		.clr_all(1'b0),
		.flags_q(ta_flags_q)
	);

	pif_flag_bank #(
		.IMPL(CELL_MASK)
	) u_cell_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.set_evt(cell_set),
		.wr_en(hit(reg_wr, reg_addr, ADDR_CELL_FLAGS)),
		.wr_val(reg_wr_data),
		.clr_all(1'b0),
		.flags_q(cell_flags_q)
	);

	// Status clears on read; an event in the reading cycle is kept
	pif_flag_bank #(
		.IMPL(EVT_MASK)
	) u_evt_stat (
		.sys_clk(sys_clk),
		.rst(rst),
		.set_evt(evt_set),
		.wr_en(1'b0),
		.wr_val(REG_RESET),
		.clr_all(hit(reg_rd, reg_addr, ADDR_EVT_STAT)),
		.flags_q(evt_stat_q)
	);

	// ********************************************************
	// Writable control registers
	// ********************************************************
	always_comb
	begin
		cell_en_d = cell_en_q;
		ta_en_d = ta_en_q;
		ctrl_d = ctrl_q;
		evt_mask_d = evt_mask_q;
		if (hit(reg_wr, reg_addr, ADDR_CELL_EN))
		begin
			cell_en_d = reg_wr_data & CELL_MASK;
		end
		if (hit(reg_wr, reg_addr, ADDR_TA_EN))
		begin
			ta_en_d = reg_wr_data & TA_MASK;
		end
		if (hit(reg_wr, reg_addr, ADDR_CTRL))
		begin
			ctrl_d = reg_wr_data & CTRL_MASK;
		end
		if (hit(reg_wr, reg_addr, ADDR_EVT_MASK))
		begin
			evt_mask_d = reg_wr_data & EVT_MASK;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cell_en_q <= REG_RESET;
			ta_en_q <= REG_RESET;
			ctrl_q <= REG_RESET;
			evt_mask_q <= REG_RESET;
		end
		else
		begin
			cell_en_q <= cell_en_d;
			ta_en_q <= ta_en_d;
			ctrl_q <= ctrl_d;
			evt_mask_q <= evt_mask_d;
		end
	end

	// ********************************************************
	// Read port and interrupt outputs
	// ********************************************************
	always_comb
	begin
		rd_data_d = REG_RESET;
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_CELL_EN: rd_data_d = cell_en_q;
				ADDR_TA_FLAGS: rd_data_d = ta_flags_q;
				ADDR_CTRL: rd_data_d = ctrl_q;
				ADDR_TA_EN: rd_data_d = ta_en_q;
				ADDR_CELL_FLAGS: rd_data_d = cell_flags_q;
				ADDR_EVT_STAT: rd_data_d = evt_stat_q;
				ADDR_EVT_MASK: rd_data_d = evt_mask_q;
				default: rd_data_d = REG_RESET;
			endcase
		end
		// Every source here is peripheral, so periph_irq_en gates all of core_irq_req but not irq
		core_irq_d = global_irq_en && periph_irq_en
			&& (any_pending(ta_flags_q, ta_en_q)
			|| any_pending(cell_flags_q, cell_en_q));
		irq_d = any_pending(evt_stat_q, evt_mask_q);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_data_q <= REG_RESET;
			core_irq_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			rd_data_q <= rd_data_d;
			core_irq_q <= core_irq_d;
			irq_q <= irq_d;
		end
	end

	assign reg_rd_data = rd_data_q;
	assign core_irq_req = core_irq_q;
	assign irq = irq_q;

	// ********************************************************
	// Assertions
	// ********************************************************
	property p_cell_en_write;
		@(posedge sys_clk) disable iff (rst)
		hit(reg_wr, reg_addr, ADDR_CELL_EN)
		|=> cell_en_q == ($past(reg_wr_data) & CELL_MASK);
	endproperty
	a_cell_en_write: assert property (p_cell_en_write)
		else $error("cell enable write not stored in bits 1:0");

	property p_periph_gate;
		@(posedge sys_clk) disable iff (rst)
		!periph_irq_en |=> !core_irq_q;
	endproperty
	a_periph_gate: assert property (p_periph_gate)
		else $error("core request raised without peripheral enable");

	property p_flag_read;
		@(posedge sys_clk) disable iff (rst)
		hit(reg_rd, reg_addr, ADDR_TA_FLAGS)
		|=> rd_data_q == $past(ta_flags_q) && rd_data_q[5:2] == 4'h0;
	endproperty
	a_flag_read: assert property (p_flag_read)
		else $error("flag register read returned wrong layout");

	property p_flag_set;
		@(posedge sys_clk) disable iff (rst)
		t2_match_evt && !global_irq_en && !ta_en_q[T2_MATCH_BIT]
		|=> ta_flags_q[T2_MATCH_BIT] ##1 ta_flags_q[T2_MATCH_BIT]
			|| $past(hit(reg_wr, reg_addr, ADDR_TA_FLAGS));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("timer2 match flag lost while disabled");

	property p_request;
		@(posedge sys_clk) disable iff (rst)
		global_irq_en && periph_irq_en
		&& ta_flags_q[T1_OVF_BIT] && ta_en_q[T1_OVF_BIT]
		|=> core_irq_q;
	endproperty
	a_request: assert property (p_request)
		else $error("enabled pending flag did not request");

	property p_no_global;
		@(posedge sys_clk) disable iff (rst)
		!global_irq_en [*2] |-> !core_irq_q;
	endproperty
	a_no_global: assert property (p_no_global)
		else $error("core request raised without global enable");

	property p_reset_clear;
		@(posedge sys_clk)
		rst |=> cell_en_q == REG_RESET && ta_flags_q == REG_RESET
			&& core_irq_q == 1'b0;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("registers not cleared by reset");

	property p_write_zero;
		@(posedge sys_clk) disable iff (rst)
		hit(reg_wr, reg_addr, ADDR_TA_FLAGS) && reg_wr_data == REG_RESET
		&& ta_set == REG_RESET
		|=> ta_flags_q == REG_RESET;
	endproperty
	a_write_zero: assert property (p_write_zero)
		else $error("writing zero did not clear flags");

	property p_cov_core;
		@(posedge sys_clk) disable iff (rst)
		!core_irq_q ##1 core_irq_q;
	endproperty
	c_cov_core: cover property (p_cov_core);

	property p_cov_irq;
		@(posedge sys_clk) disable iff (rst)
		!irq_q ##1 irq_q;
	endproperty
	c_cov_irq: cover property (p_cov_irq);

	property p_cov_set_clear;
		@(posedge sys_clk) disable iff (rst)
		cell1_evt && hit(reg_wr, reg_addr, ADDR_CELL_FLAGS);
	endproperty
	c_cov_set_clear: cover property (p_cov_set_clear);

endmodule // pif_irq_regs

// [dv/tb_top.sv]
`timescale 1ns/1ps

module tb_top
	import pif_pkg::*;
;
	logic sys_clk;
	logic rst;
	logic reg_wr;
	logic reg_rd;
	logic [PIF_AW-1:0] reg_addr;
	logic [PIF_DW-1:0] reg_wr_data;
	logic [PIF_DW-1:0] reg_rd_data;
	logic [PIF_DW-1:0] ev;
	logic [PIF_DW-1:0] rd;
	logic [PIF_DW-1:0] v;
	logic [PIF_DW-1:0] e;
	logic [PIF_DW-1:0] s;
	logic [PIF_AW-1:0] en_a;
	logic [PIF_AW-1:0] fl_a;
	logic core_irq_req;
	logic irq;
	int n_mismatch;
	int checks;
	int cyc;
	int srcs[6] = '{7, 6, 1, 0, 3, 2};

	// Event lines laid out like the event status register
	pif_irq_regs u_pif_irq_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.t1_gate_evt(ev[7]),
		.conv_done_evt(ev[6]),
		.t2_match_evt(ev[1]),
		.t1_overflow_evt(ev[0]),
		.cell1_evt(ev[2]),
		.cell2_evt(ev[3]),
		.reg_rd_data(reg_rd_data),
		.core_irq_req(core_irq_req),
		.irq(irq)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ********************************************************
	// Checking and bus tasks
	// ********************************************************
	task automatic final_report();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe, so sample there
	task automatic rdr(input logic [2:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rd_data;
	endtask

	task automatic pulse(input logic [7:0] p);
		@(posedge sys_clk);
		ev <= p & EVT_MASK;
		@(posedge sys_clk);
		ev <= 8'h00;
	endtask

	// Request outputs lag the register state by one edge
	task automatic smp(input logic r, input logic i);
		@(posedge sys_clk);
		#1 check(core_irq_req, r);
		check(irq, i);
	endtask

	function automatic logic [7:0] mk(input int a);
		case (a)
			0, 4: return CELL_MASK;
			1, 3: return TA_MASK;
			2: return CTRL_MASK;
			6: return EVT_MASK;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] exp_cell(input logic [7:0] p);
		return {6'h00, p[3], p[2]};
	endfunction

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wr_data = 8'h00;
		ev = 8'h00;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		void'($urandom(72));
		for (int a = 0; a < 8; a++)
		begin
			rdr(a[2:0]);
			check(rd, 8'h00);
		end
		for (int k = 0; k < 5; k++)
		begin
			for (int a = 0; a < 8; a++)
			begin
				v = (k == 0) ? 8'hff : 8'($urandom);
				if (a != 5)
				begin
					wr(a[2:0], v);
					rdr(a[2:0]);
					check(rd, v & mk(a));
				end
			end
		end
		for (int a = 0; a < 8; a++)
			wr(a[2:0], 8'h00);
		rdr(ADDR_EVT_STAT);
		// Corner: an event beats a clearing write, then a clearing read
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ADDR_CELL_FLAGS;
		reg_wr_data <= 8'h00;
		ev <= 8'h04;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= ADDR_EVT_STAT;
		ev <= 8'h04;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		ev <= 8'h00;
		#1 check(reg_rd_data, 8'h04);
		@(posedge sys_clk);
		#1 check(reg_rd_data, 8'h00);
		rdr(ADDR_EVT_STAT);
		check(rd, 8'h04);
		rdr(ADDR_CELL_FLAGS);
		check(rd, 8'h01);
		wr(ADDR_CELL_FLAGS, 8'h00);
		rdr(ADDR_EVT_STAT);
		check(rd, 8'h00);
		// Flags record events with every enable clear
		repeat (8)
		begin
			v = 8'($urandom) & EVT_MASK;
			if (v == 8'h00)
				v = 8'h81;
			pulse(v);
			smp(1'b0, 1'b0);
			rdr(ADDR_TA_FLAGS);
			check(rd, v & TA_MASK);
			rdr(ADDR_CELL_FLAGS);
			check(rd, exp_cell(v));
			rdr(ADDR_EVT_STAT);
			check(rd, v);
			rdr(ADDR_EVT_STAT);
			check(rd, 8'h00);
			wr(ADDR_TA_FLAGS, 8'h00);
			wr(ADDR_CELL_FLAGS, 8'h00);
			rdr(ADDR_TA_FLAGS);
			check(rd, 8'h00);
		end
		// Gating of each source by its own, global and peripheral enables
		foreach (srcs[i])
		begin
			s = 8'h01 << srcs[i];
			en_a = (srcs[i] inside {2, 3}) ? ADDR_CELL_EN : ADDR_TA_EN;
			fl_a = (srcs[i] inside {2, 3}) ? ADDR_CELL_FLAGS : ADDR_TA_FLAGS;
			e = (srcs[i] inside {2, 3}) ? (s >> 2) : s;
			wr(ADDR_CTRL, 8'h80);
			wr(en_a, e);
			pulse(s);
			smp(1'b0, 1'b0);
			wr(ADDR_EVT_MASK, s);
			smp(1'b0, 1'b1);
			wr(ADDR_CTRL, 8'hc0);
			smp(1'b1, 1'b1);
			wr(ADDR_CTRL, 8'h40);
			smp(1'b0, 1'b1);
			wr(ADDR_CTRL, 8'hc0);
			wr(en_a, 8'h00);
			smp(1'b0, 1'b1);
			rdr(fl_a);
			check(rd, e);
			rdr(ADDR_EVT_STAT);
			check(rd, s);
			smp(1'b0, 1'b0);
			// Clearing before enabling avoids a stale request
			wr(fl_a, 8'h00);
			wr(en_a, e);
			smp(1'b0, 1'b0);
			wr(en_a, 8'h00);
			wr(ADDR_EVT_MASK, 8'h00);
			wr(ADDR_CTRL, 8'h00);
		end
		final_report();
	end
endmodule // tb_top
